/* hw/debug_regs_pkg.sv */
// constants for the background debug register window and pin logic
// assumes a single 100 MHz core clock and byte-wide register accesses
package debug_regs_pkg;
   localparam logic [15:0] ADDR_STATUS = 16'hff01;
   localparam logic [15:0] ADDR_FLAGS = 16'hff06;
   localparam logic [15:0] ADDR_POSITION = 16'hff07;
   localparam int BIT_ENABLE = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_TAG = 5;
   localparam int BIT_SDV = 4;
   localparam int BIT_STEP = 3;
   localparam int BIT_CLKSEL = 2;
   localparam int BIT_UNSECURED_FLAG = 1;
   localparam int POS_LO = 3;
   localparam int POS_HI = 6;
   localparam int INIT_LO = 11;
   localparam int INIT_HI = 14;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'hd0;
   localparam logic [7:0] FLAGS_RESET_SPECIAL = 8'hd8;
   localparam logic [7:0] READ_ZERO = 8'h00;
   localparam int TAG_DELAY_CYC = 16;
   localparam int CLK_SETTLE_CYC = 150;
   localparam logic [4:0] TAG_DELAY = 5'(TAG_DELAY_CYC);
   localparam logic [7:0] CLK_SETTLE = 8'(CLK_SETTLE_CYC);
   typedef enum logic [1:0] {
      WR_NONE,
      WR_HW_CMD,
      WR_FW_CMD,
      WR_OTHER
   } writer_t;
   typedef enum {
      TAG_IDLE,
      TAG_WAIT,
      TAG_ON
   } tag_state_t;
endpackage : debug_regs_pkg

/* hw/falling_sampler.sv */
// samples a tag pin at each falling edge of the external bus clock
// external bus clock and pin are synchronous samples of the core clock
`timescale 1ns/1ps
module falling_sampler
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic bus_clk_in,
   input wire logic pin_in,
   input wire logic arm_in,
   output logic hit_out
);
   logic bus_clk_d;
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         bus_clk_d <= 1'b0;
      else
         bus_clk_d <= bus_clk_in;
   end
   // active low tag caught on the falling edge only
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         hit_out <= 1'b0;
      else
         hit_out <= arm_in && bus_clk_d && !bus_clk_in && !pin_in;
   end
endmodule : falling_sampler

/* hw/background_debug_status_regs.sv */
// status, flags holding and register-position window of the debug unit
// the serial engine decodes commands and presents register accesses here
//
// Overview of operation
// - background pin is mode strap during reset
// - high tag pin low tags upper half
// - low tag needs low strobe enabled too
// - status written only by debug register commands; flags by any writer
// - decode status, flags, position at three addresses
// - enable flag gates activation, hardware commands run
// - firmware sets enable in special mode; secured waits erase verify
// - entry sets active flag and maps firmware
// - only hardware sets active; timed store clears
// - tag enable set by tag-and-go, cleared on entry
// - sixteen cycles later serial off, tagging on
// - shift valid set at data end, cleared later
// - single-step flag holds through back-to-back steps
// - clock select written only by debug commands
// - unsecured reads one in special mode when secured but erased
// - alternate clock only when pll one, select zero
// - new clock guaranteed after 150 cycles
// - position bits mirror register-block base bits
`timescale 1ns/1ps
module background_debug_status_regs
   import debug_regs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic background_pin_in,
   output logic background_pin_out,
   output logic background_pin_oe_out,
   input wire logic serial_tx_in,
   input wire logic serial_tx_en_in,
   input wire logic external_bus_clock_in,
   input wire logic high_tag_pin_in,
   input wire logic low_tag_pin_in,
   input wire logic low_strobe_en_in,
   input wire logic reg_access_in,
   input wire logic reg_write_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire writer_t reg_writer_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_ack_out,
   input wire logic special_single_chip_in,
   input wire logic secured_in,
   input wire logic erase_verified_in,
   input wire logic fw_start_in,
   input wire logic enter_req_in,
   input wire logic exit_store_in,
   input wire logic fw_data_done_in,
   input wire logic cmd_received_in,
   input wire logic single_step_cmd_in,
   input wire logic tag_and_go_cmd_in,
   input wire logic pll_select_in,
   input wire logic [15:0] register_block_init_in,
   input wire logic [7:0] saved_flags_in,
   input wire logic saved_flags_load_in,
   output logic mode_special_out,
   output logic debug_active_out,
   output logic firmware_mapped_out,
   output logic serial_enabled_out,
   output logic tag_high_out,
   output logic tag_low_out,
   output logic alt_clock_sel_out,
   output logic clock_stable_out
);
   logic debug_enable_flag;
   logic debug_active_flag;
   logic tag_enable_flag;
   logic shift_data_valid_flag;
   logic single_step_flag;
   logic clock_select_flag;
   logic unsecured_flag;
   logic [7:0] saved_flags_holding;
   logic in_reset;
   logic wr_status;
   logic wr_flags;
   logic rd_hit;
   logic [7:0] status_view;
   logic [7:0] position_view;
   logic [7:0] next_rdata;
   logic tag_arm;
   logic low_arm;
   logic hit_high;
   logic hit_low;
   logic [4:0] tag_count;
   logic [7:0] settle_count;
   logic clock_select_d;
   tag_state_t tag_state;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         in_reset <= 1'b1;
      else
         in_reset <= 1'b0;
   end
   // the strap is taken on the first clock after release, never async
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         mode_special_out <= 1'b0;
      else if (in_reset)
         mode_special_out <= !background_pin_in;
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         background_pin_out <= 1'b0;
         background_pin_oe_out <= 1'b0;
      end
      else
      begin
         background_pin_out <= serial_tx_in;
         background_pin_oe_out <= serial_tx_en_in && !in_reset &&
            serial_enabled_out;
      end
   end

   assign wr_status = reg_access_in && reg_write_in && !in_reset &&
      reg_addr_in == ADDR_STATUS &&
      (reg_writer_in == WR_HW_CMD || reg_writer_in == WR_FW_CMD);
   assign wr_flags = reg_access_in && reg_write_in && !in_reset &&
      reg_addr_in == ADDR_FLAGS && reg_writer_in != WR_NONE;

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         debug_enable_flag <= 1'b0;
      else if (fw_start_in && mode_special_out &&
               (!secured_in || erase_verified_in))
         debug_enable_flag <= 1'b1;
      else if (wr_status)
         debug_enable_flag <= reg_wdata_in[BIT_ENABLE];
   end

   // only timed store clears; set wins
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         debug_active_flag <= 1'b0;
      else if (enter_req_in && debug_enable_flag)
         debug_active_flag <= 1'b1;
      else if (exit_store_in)
         debug_active_flag <= 1'b0;
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         debug_active_out <= 1'b0;
         firmware_mapped_out <= 1'b0;
      end
      else
      begin
         debug_active_out <= debug_active_flag;
         firmware_mapped_out <= debug_active_flag;
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         tag_enable_flag <= 1'b0;
      else if (enter_req_in && debug_enable_flag)
         tag_enable_flag <= 1'b0;
      else if (tag_and_go_cmd_in)
         tag_enable_flag <= 1'b1;
      else if (wr_status)
         tag_enable_flag <= reg_wdata_in[BIT_TAG];
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tag_state <= TAG_IDLE;
         tag_count <= '0;
      end
      else
      begin
         case (tag_state)
            TAG_IDLE:
               if (tag_and_go_cmd_in || (wr_status &&
                   reg_wdata_in[BIT_TAG]))
               begin
                  tag_state <= TAG_WAIT;
                  tag_count <= '0;
               end
            TAG_WAIT:
               if (!tag_enable_flag)
                  tag_state <= TAG_IDLE;
               else if (tag_count == TAG_DELAY - 5'd1)
                  tag_state <= TAG_ON;
               else
                  tag_count <= tag_count + 5'd1;
            TAG_ON:
               if (!tag_enable_flag)
                  tag_state <= TAG_IDLE;
            default:
               tag_state <= TAG_IDLE;
         endcase
      end
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         serial_enabled_out <= 1'b1;
      else
         serial_enabled_out <= tag_state != TAG_ON;
   end

   assign tag_arm = tag_state == TAG_ON;
   assign low_arm = tag_arm && low_strobe_en_in;
   falling_sampler u_high
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .bus_clk_in(external_bus_clock_in),
      .pin_in(high_tag_pin_in),
      .arm_in(tag_arm),
      .hit_out(hit_high)
   );
   falling_sampler u_low
   (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .bus_clk_in(external_bus_clock_in),
      .pin_in(low_tag_pin_in),
      .arm_in(low_arm),
      .hit_out(hit_low)
   );
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         tag_high_out <= 1'b0;
         tag_low_out <= 1'b0;
      end
      else
      begin
         tag_high_out <= hit_high;
         tag_low_out <= hit_low;
      end
   end

   // data valid; set wins over clear
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         shift_data_valid_flag <= 1'b0;
      else if (fw_data_done_in)
         shift_data_valid_flag <= 1'b1;
      else if (cmd_received_in || exit_store_in)
         shift_data_valid_flag <= 1'b0;
      else if (wr_status)
         shift_data_valid_flag <= reg_wdata_in[BIT_SDV];
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         single_step_flag <= 1'b0;
      else if (cmd_received_in)
         single_step_flag <= single_step_cmd_in;
      else if (wr_status)
         single_step_flag <= reg_wdata_in[BIT_STEP];
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         clock_select_flag <= 1'b0;
      else if (wr_status)
         clock_select_flag <= reg_wdata_in[BIT_CLKSEL];
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         unsecured_flag <= 1'b0;
      else
         unsecured_flag <= mode_special_out && secured_in &&
            erase_verified_in;
   end

   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         alt_clock_sel_out <= 1'b0;
      else
         alt_clock_sel_out <= pll_select_in && !clock_select_flag;
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clock_select_d <= 1'b0;
         settle_count <= '0;
         clock_stable_out <= 1'b1;
      end
      else
      begin
         clock_select_d <= clock_select_flag;
         if (clock_select_d != clock_select_flag)
         begin
            settle_count <= '0;
            clock_stable_out <= 1'b0;
         end
         else if (!clock_stable_out)
         begin
            if (settle_count == CLK_SETTLE - 8'd1)
               clock_stable_out <= 1'b1;
            else
               settle_count <= settle_count + 8'd1;
         end
      end
   end

   // flags holding: cpu save on entry beats a register write
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         saved_flags_holding <= FLAGS_RESET;
      else if (in_reset && !background_pin_in)
         saved_flags_holding <= FLAGS_RESET_SPECIAL;
      else if (saved_flags_load_in)
         saved_flags_holding <= saved_flags_in;
      else if (wr_flags)
         saved_flags_holding <= reg_wdata_in;
   end

   always_comb
   begin
      status_view = READ_ZERO;
      status_view[BIT_ENABLE] = debug_enable_flag;
      status_view[BIT_ACTIVE] = debug_active_flag;
      status_view[BIT_TAG] = tag_enable_flag;
      status_view[BIT_SDV] = shift_data_valid_flag;
      status_view[BIT_STEP] = single_step_flag;
      status_view[BIT_CLKSEL] = clock_select_flag;
      status_view[BIT_UNSECURED_FLAG] = unsecured_flag;
   end
   always_comb
   begin
      position_view = READ_ZERO;
      position_view[POS_HI:POS_LO] =
         register_block_init_in[INIT_HI:INIT_LO];
   end
   always_comb
   begin
      rd_hit = reg_access_in && !reg_write_in;
      case (reg_addr_in)
         ADDR_STATUS: next_rdata = status_view;
         ADDR_FLAGS: next_rdata = saved_flags_holding;
         ADDR_POSITION: next_rdata = position_view;
         default: next_rdata = READ_ZERO;
      endcase
   end
   always_ff @(posedge ref_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         reg_rdata_out <= READ_ZERO;
         reg_ack_out <= 1'b0;
      end
      else
      begin
         reg_ack_out <= reg_access_in && !in_reset;
         if (rd_hit)
            reg_rdata_out <= next_rdata;
      end
   end
endmodule : background_debug_status_regs

/* verif/debug_regs_properties.sv */
// assertions on the debug register window ports
// bound to the design top; one clock domain
`timescale 1ns/1ps
module debug_regs_properties
   import debug_regs_pkg::*;
(
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic reg_access_in,
   input wire logic reg_write_in,
   input wire logic [15:0] reg_addr_in,
   input wire logic [15:0] register_block_init_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_ack_out,
   input wire logic tag_and_go_cmd_in,
   input wire logic enter_req_in,
   input wire logic exit_store_in,
   input wire logic low_strobe_en_in,
   input wire logic pll_select_in,
   input wire logic serial_enabled_out,
   input wire logic tag_high_out,
   input wire logic tag_low_out,
   input wire logic alt_clock_sel_out,
   input wire logic debug_active_out,
   input wire logic clock_stable_out,
   input wire logic mode_special_out
);
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);
   sequence s_tag_armed;
      tag_and_go_cmd_in ##1 serial_enabled_out [*8];
   endsequence
   sequence s_pos_read;
      reg_access_in && !reg_write_in && reg_addr_in == ADDR_POSITION;
   endsequence
   property p_noack;
      !reg_access_in |=> !reg_ack_out;
   endproperty
   property p_pos;
      s_pos_read |=> reg_ack_out && reg_rdata_out ==
         {1'b0, $past(register_block_init_in[INIT_HI:INIT_LO]), 3'b000};
   endproperty
   // the strap lands on the first clock after release, so only check
   // from the third clock on
   property p_mode;
      $past(rst_n_in, 2) |-> $stable(mode_special_out);
   endproperty
   property p_set;
      $rose(debug_active_out) |-> $past(enter_req_in)
         || $past(enter_req_in, 2);
   endproperty
   property p_clr;
      $fell(debug_active_out) |-> $past(exit_store_in)
         || $past(exit_store_in, 2);
   endproperty
   property p_tag;
      s_tag_armed |-> ##[7:12] !serial_enabled_out;
   endproperty
   property p_idle;
      serial_enabled_out |-> !tag_high_out && !tag_low_out;
   endproperty
   property p_low;
      !low_strobe_en_in [*3] |-> !tag_low_out;
   endproperty
   property p_alt;
      !pll_select_in [*3] |-> !alt_clock_sel_out;
   endproperty
   property p_stab;
      $fell(clock_stable_out) |=> !clock_stable_out [*8];
   endproperty
   a_noack: assert property (p_noack) else $error("stray ack");
   a_pos: assert property (p_pos) else $error("position read");
   a_mode: assert property (p_mode) else $error("mode moved");
   a_set: assert property (p_set) else $error("active set");
   a_clr: assert property (p_clr) else $error("active clear");
   a_tag: assert property (p_tag) else $error("serial stays on");
   a_idle: assert property (p_idle) else $error("tag w/o tagging");
   a_low: assert property (p_low) else $error("low tag w/o strobe");
   a_alt: assert property (p_alt) else $error("alt clock w/o pll");
   a_stab: assert property (p_stab) else $error("settle too short");
endmodule : debug_regs_properties

bind background_debug_status_regs debug_regs_properties
   i_debug_regs_properties
(
   .ref_clk_in(ref_clk_in),
   .rst_n_in(rst_n_in),
   .reg_access_in(reg_access_in),
   .reg_write_in(reg_write_in),
   .reg_addr_in(reg_addr_in),
   .register_block_init_in(register_block_init_in),
   .reg_rdata_out(reg_rdata_out),
   .reg_ack_out(reg_ack_out),
   .tag_and_go_cmd_in(tag_and_go_cmd_in),
   .enter_req_in(enter_req_in),
   .exit_store_in(exit_store_in),
   .low_strobe_en_in(low_strobe_en_in),
   .pll_select_in(pll_select_in),
   .serial_enabled_out(serial_enabled_out),
   .tag_high_out(tag_high_out),
   .tag_low_out(tag_low_out),
   .alt_clock_sel_out(alt_clock_sel_out),
   .debug_active_out(debug_active_out),
   .clock_stable_out(clock_stable_out),
   .mode_special_out(mode_special_out)
);

/* verif/host_link_model.sv */
// far-side host model for the single-wire background line
// released line floats high through the pull-up
`timescale 1ns/1ps
module host_link_model
(
   input wire logic strap_low_in,
   input wire logic drive_oe_in,
   input wire logic drive_val_in,
   output logic line_out
);
   // strap during reset
   // the host keeps the strap past release: the chip takes it on its
   // first clock after reset, so dropping it with reset would lose it
   always_comb
   begin
      if (drive_oe_in)
         line_out = drive_val_in;
      else if (strap_low_in)
         line_out = 1'b0;
      else
         line_out = 1'b1;
   end
endmodule : host_link_model

/* verif/tb_background_debug_status_regs.sv */
// self-checking bench for the debug register window
// host model resolves the background line; one 100 MHz clock
`timescale 1ns/1ps
module tb_background_debug_status_regs
   import debug_regs_pkg::*;
();
   logic clk, rst_n, tx, tx_en, ebc, thi, tlo, lse, acc_r, wr, sp, sec;
   logic ev, fws, ent, ext, fdd, cmd, stp, tgo, pll, sfll, strap_low;
   logic [15:0] addr, init;
   logic [7:0] wd, sfl, rdo;
   writer_t wtr;
   logic pin_o, pin_oe, ack, msp, act, map, ser, th, tl, alt, cst, bg;
   logic seen_h, seen_l;
   int err_total = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [33:0] rows [9] = '{
      {ADDR_POSITION, 8'hff, WR_HW_CMD, 8'h78},
      {ADDR_FLAGS, 8'h5a, WR_FW_CMD, 8'h5a},
      {ADDR_FLAGS, 8'ha5, WR_NONE, 8'h5a},
      {16'hff00, 8'hff, WR_HW_CMD, 8'h00},
      {16'hff08, 8'hff, WR_HW_CMD, 8'h00},
      {ADDR_STATUS, 8'h84, WR_HW_CMD, 8'h84},
      {ADDR_STATUS, 8'h00, WR_OTHER, 8'h84},
      {ADDR_STATUS, 8'h80, WR_FW_CMD, 8'h80},
      {ADDR_STATUS, 8'hff, WR_NONE, 8'h80}};

   background_debug_status_regs i_background_debug_status_regs (
      .ref_clk_in(clk), .rst_n_in(rst_n), .background_pin_in(bg),
      .background_pin_out(pin_o), .background_pin_oe_out(pin_oe),
      .serial_tx_in(tx), .serial_tx_en_in(tx_en),
      .external_bus_clock_in(ebc), .high_tag_pin_in(thi),
      .low_tag_pin_in(tlo), .low_strobe_en_in(lse),
      .reg_access_in(acc_r), .reg_write_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wd), .reg_writer_in(wtr), .reg_rdata_out(rdo),
      .reg_ack_out(ack), .special_single_chip_in(sp),
      .secured_in(sec), .erase_verified_in(ev), .fw_start_in(fws),
      .enter_req_in(ent), .exit_store_in(ext), .fw_data_done_in(fdd),
      .cmd_received_in(cmd), .single_step_cmd_in(stp),
      .tag_and_go_cmd_in(tgo), .pll_select_in(pll),
      .register_block_init_in(init), .saved_flags_in(sfl),
      .saved_flags_load_in(sfll), .mode_special_out(msp),
      .debug_active_out(act), .firmware_mapped_out(map),
      .serial_enabled_out(ser), .tag_high_out(th), .tag_low_out(tl),
      .alt_clock_sel_out(alt), .clock_stable_out(cst));

   host_link_model i_host_link_model (
      .strap_low_in(strap_low), .drive_oe_in(pin_oe),
      .drive_val_in(pin_o), .line_out(bg));

   task automatic close_out();
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick

   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h want %h", $time, s, e);
      end
   endtask : chk

   // single-byte access, held to the taking edge
   task automatic acc(input logic w, input logic [15:0] a,
      input logic [7:0] d, input writer_t k);
      int n;
      tick(1);
      acc_r = 1'b1;
      wr = w;
      addr = a;
      wd = d;
      wtr = k;
      tick(1);
      acc_r = 1'b0;
      n = 0;
      while (ack !== 1'b1 && n < 4)
      begin
         tick(1);
         n++;
      end
      chk(ack, 1'b1);
   endtask : acc

   task automatic rdchk(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00, WR_NONE);
      chk(rdo, e);
   endtask : rdchk

   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(2);
   endtask : pulse

   task automatic hit();
      ebc = 1'b1;
      tick(1);
      ebc = 1'b0;
      tick(4);
   endtask : hit

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // hang guard and one-cycle tag pulse capture
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (th === 1'b1)
         seen_h <= 1'b1;
      if (tl === 1'b1)
         seen_l <= 1'b1;
      if (cyc == 5000)
      begin
         err_total++;
         close_out();
      end
   end

   initial
   begin
      {rst_n, tx, tx_en, ebc, acc_r, wr, sp, sec, ev, fws, ent} = '0;
      {ext, fdd, cmd, stp, tgo, lse, sfll, strap_low, pll} = '0;
      {thi, tlo, seen_h, seen_l} = 4'b1100;
      {addr, wd, sfl} = '0;
      init = 16'h7800;
      wtr = WR_NONE;
      tick(16);
      rst_n = 1'b1;
      tick(2);
      chk(msp, 1'b0);
      chk({ser, cst, act, map, alt}, 5'b11000);
      rdchk(ADDR_FLAGS, FLAGS_RESET);
      tx_en = 1'b1;
      tick(2);
      chk({pin_oe, bg}, 2'b10);
      tx_en = 1'b0;
      pll = 1'b1;
      pulse(ent);
      chk(act, 1'b0);
      foreach (rows[i])
      begin
         acc(1'b1, rows[i][33:18], rows[i][17:10], writer_t'(rows[i][9:8]));
         rdchk(rows[i][33:18], rows[i][7:0]);
      end
      tick(160);
      chk(alt, 1'b1);
      acc(1'b1, ADDR_STATUS, 8'h84, WR_HW_CMD);
      tick(2);
      chk(cst, 1'b0);
      tick(140);
      chk(cst, 1'b0);
      tick(20);
      chk({cst, alt}, 2'b10);
      acc(1'b1, ADDR_STATUS, 8'hc4, WR_FW_CMD);
      chk(act, 1'b0);
      sfl = 8'h3c;
      pulse(sfll);
      rdchk(ADDR_FLAGS, 8'h3c);
      pulse(ent);
      chk({act, map}, 2'b11);
      rdchk(ADDR_STATUS, 8'hc4);
      pulse(fdd);
      rdchk(ADDR_STATUS, 8'hd4);
      stp = 1'b1;
      pulse(cmd);
      rdchk(ADDR_STATUS, 8'hcc);
      pulse(cmd);
      rdchk(ADDR_STATUS, 8'hcc);
      stp = 1'b0;
      pulse(cmd);
      rdchk(ADDR_STATUS, 8'hc4);
      pulse(fdd);
      pulse(ext);
      chk({act, map}, 2'b00);
      rdchk(ADDR_STATUS, 8'h84);
      {thi, tlo} = 2'b00;
      hit();
      chk({seen_h, seen_l}, 2'b00);
      pulse(tgo);
      rdchk(ADDR_STATUS, 8'ha4);
      tick(20);
      chk(ser, 1'b0);
      hit();
      chk({seen_h, seen_l}, 2'b10);
      lse = 1'b1;
      hit();
      chk(seen_l, 1'b1);
      {thi, tlo} = 2'b11;
      pulse(ent);
      rdchk(ADDR_STATUS, 8'hc4);
      pulse(ext);
      rst_n = 1'b0;
      strap_low = 1'b1;
      sec = 1'b1;
      tick(16);
      rst_n = 1'b1;
      tick(2);
      chk(msp, 1'b1);
      strap_low = 1'b0;
      rdchk(ADDR_FLAGS, FLAGS_RESET_SPECIAL);
      pulse(fws);
      rdchk(ADDR_STATUS, 8'h00);
      ev = 1'b1;
      pulse(fws);
      rdchk(ADDR_STATUS, 8'h82);
      close_out();
   end
endmodule : tb_background_debug_status_regs
